// ### hdl/tle_core.sv
// transactional execution control for one logical processor, with apb registers
//
// Summary of operation
// - hinted acquire: lock joins read-set only, no write issued, transaction starts
// - own reads of an elided lock return the value the acquire would write
// - other processors reading an elided lock see it free, no conflict
// - data conflicts are found in hardware and abort the transaction
// - hinted release restoring old value is suppressed, kept out of write-set
// - failed hinted region re-runs without elision, with real lock writes
// - without elision support the hints are ignored like legacy repeat prefixes
// - region begin offset forms the fallback address
// - region abort restores start state, writes status, jumps to fallback
// - explicit abort loads its 8-bit immediate into the status word
// - elision support reported in bit 4 of leaf 07H second word
// - region support in bit 11; begin, end, abort fault when absent
// - status test reports transactional state, faults without either mode
// - release size, address or value mismatch, or line crossing, falls back
// - other writes to elided lock or recursive acquire abort; unhinted acquire and release writes to it do not abort
// - conflicts are tracked per cache line
// - nested regions act as one, abort returns to outermost start
// - hidden hint nest counter, start at zero to one, commit at zero
// - hint nest counter beyond its limit aborts
// - each elided lock held in a slot from acquire to its release
// - with slots full, further locks go to write-set, still transactional
// - commit only with all pairs matched; otherwise restart without elision
// - region nest counter, commit at zero, abort beyond limit
// - abort status bit layout with immediate in bits 31:24
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tle_core #(
  parameter int ADDR_W      = 32,
  parameter int LINE_BITS   = 6,
  parameter int SET_DEPTH   = 8,
  parameter int HNEST_MAX   = 8,
  parameter int RNEST_MAX   = 7,
  parameter int SLOTS       = 2,
  parameter bit ELIDE_IMPL  = 1'b1,
  parameter bit REGION_IMPL = 1'b1
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              op_valid,
  output logic                   op_ready,
  input  wire logic [3:0]        op_kind,
  input  wire logic              op_hint,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [1:0]        op_size,
  input  wire logic [31:0]       op_wdata,
  input  wire logic [31:0]       op_mem_rdata,
  input  wire logic [7:0]        op_imm,
  input  wire logic [31:0]       op_offset,
  input  wire logic [ADDR_W-1:0] op_pc,
  input  wire logic [ADDR_W-1:0] op_next_pc,
  output logic                   res_valid,
  output logic [31:0]            res_data,
  output logic                   fault_invalid_op,
  output logic                   redirect_valid,
  output logic [ADDR_W-1:0]      redirect_pc,
  output logic                   status_valid,
  output logic [31:0]            status_result_reg,
  output logic                   commit_pulse,
  output logic                   abort_pulse,
  output logic                   in_tx,
  output logic                   mem_wr_valid,
  output logic [ADDR_W-1:0]      mem_wr_addr,
  output logic [31:0]            mem_wr_data,
  output logic [1:0]             mem_wr_size,
  output logic                   mem_wr_spec,
  input  wire logic              snoop_valid,
  input  wire logic              snoop_write,
  input  wire logic [ADDR_W-1:0] snoop_addr
);

  localparam int NW = 8;
  localparam int SW = (SLOTS > 1) ? $clog2(SLOTS) : 1;
  localparam int LW = ADDR_W - LINE_BITS;
  localparam logic [NW-1:0] HMAX = NW'(HNEST_MAX);
  localparam logic [NW-1:0] RMAX = NW'(RNEST_MAX);

  initial begin
    if (HNEST_MAX < 1 || HNEST_MAX > 255 || RNEST_MAX < 1 || RNEST_MAX > 255)
      $error("tle_core: nest limits must be 1..255");
    if (SLOTS < 1 || SLOTS > 255 || LINE_BITS < 2 || LINE_BITS >= ADDR_W || ADDR_W > 32)
      $error("tle_core: bad slot count or line size");
  end

  // lowest free elided-lock slot; msb says whether one was found
  function automatic logic [SW:0] first_free(input logic [SLOTS-1:0] v);
    logic [SW:0] r;
    r = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (!v[i]) r = {1'b1, SW'(i)};
    end
    return r;
  endfunction

  tle_pkg::tle_mode_e mode_q, mode_d;
  logic [NW-1:0]      hnest_q, hnest_d, rnest_q, rnest_d, pnest_q, pnest_d;
  logic               no_elide_q, no_elide_d;
  logic [ADDR_W-1:0]  rpc_q, rpc_d, fb_q, fb_d;
  logic [SLOTS-1:0]   slot_v_q, slot_v_d;
  logic [ADDR_W-1:0]  slot_a_q [SLOTS];
  logic [1:0]         slot_sz_q [SLOTS];
  logic [31:0]        slot_old_q [SLOTS];
  logic [31:0]        slot_new_q [SLOTS];
  logic [SLOTS-1:0]   lock_hit;
  logic [SW-1:0]      hit_idx;
  logic [SW:0]        free_slot;
  logic [1:0]         ctrl_q;
  logic [31:0]        ab_st_q, nabort_q, ncommit_q;
  logic               elide_on, region_on, fire, crosses;
  logic               ab_go, cm_go, set_clr, slot_take, slot_free;
  logic [31:0]        ab_st, res_d;
  logic               res_v, flt, wr_go, wr_spec, rs_ins, ws_ins;
  logic               rs_hit, ws_hit, rs_ovf, ws_ovf;
  logic [LINE_BITS:0] end_off;

  assign elide_on  = ELIDE_IMPL && ctrl_q[tle_pkg::TLE_CTRL_ELIDE_BIT];
  assign region_on = REGION_IMPL && ctrl_q[tle_pkg::TLE_CTRL_REGION_BIT];
  assign op_ready  = !redirect_valid;
  assign fire      = op_valid && op_ready;
  assign in_tx     = (mode_q != tle_pkg::TLE_MD_IDLE);
  assign free_slot = first_free(slot_v_q);
  assign end_off   = {1'b0, op_addr[LINE_BITS-1:0]} + ((LINE_BITS + 1)'(1) << op_size);
  assign crosses   = end_off > ((LINE_BITS + 1)'(1) << LINE_BITS);

  // elided-lock address match against every slot
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_hit
      assign lock_hit[g] = slot_v_q[g] && (slot_a_q[g] == op_addr);
    end
  endgenerate

  always_comb begin
    hit_idx = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (lock_hit[i]) hit_idx = SW'(i);
    end
  end

  // read-set and write-set at cache-line granularity
  tle_line_set #(.LINE_W(LW), .DEPTH(SET_DEPTH)) u_rset (
    .pclk      (pclk),
    .presetn   (presetn),
    .clr       (set_clr),
    .ins_valid (rs_ins && !ab_go),
    .ins_line  (op_addr[ADDR_W-1:LINE_BITS]),
    .chk_line  (snoop_addr[ADDR_W-1:LINE_BITS]),
    .chk_hit   (rs_hit),
    .ins_ovf   (rs_ovf)
  );
  tle_line_set #(.LINE_W(LW), .DEPTH(SET_DEPTH)) u_wset (
    .pclk      (pclk),
    .presetn   (presetn),
    .clr       (set_clr),
    .ins_valid (ws_ins && !ab_go),
    .ins_line  (op_addr[ADDR_W-1:LINE_BITS]),
    .chk_line  (snoop_addr[ADDR_W-1:LINE_BITS]),
    .chk_hit   (ws_hit),
    .ins_ovf   (ws_ovf)
  );

  // instruction decision: counters, slots, aborts and commits
  always_comb begin
    mode_d = mode_q;
    hnest_d = hnest_q;
    rnest_d = rnest_q;
    pnest_d = pnest_q;
    no_elide_d = no_elide_q;
    rpc_d = rpc_q;
    fb_d = fb_q;
    slot_v_d = slot_v_q;
    ab_go = 1'b0;
    ab_st = '0;
    cm_go = 1'b0;
    slot_take = 1'b0;
    slot_free = 1'b0;
    res_v = 1'b0;
    res_d = '0;
    flt = 1'b0;
    wr_go = 1'b0;
    wr_spec = 1'b0;
    rs_ins = 1'b0;
    ws_ins = 1'b0;
    if (fire) begin
      case (tle_pkg::tle_op_e'(op_kind))
        tle_pkg::TLE_OP_LOAD: begin
          res_v = 1'b1;
          res_d = (|lock_hit) ? slot_new_q[hit_idx] : op_mem_rdata;
          rs_ins = in_tx;
        end
        tle_pkg::TLE_OP_STORE: begin
          if (mode_q == tle_pkg::TLE_MD_ELIDE && (|lock_hit)) begin
            ab_go = 1'b1;
          end else begin
            wr_go = 1'b1;
            wr_spec = in_tx;
            ws_ins = in_tx;
          end
        end
        tle_pkg::TLE_OP_ACQ: begin
          res_v = 1'b1;
          res_d = op_mem_rdata;
          if (op_hint && elide_on && !no_elide_q && mode_q != tle_pkg::TLE_MD_REGION
              && !(mode_q == tle_pkg::TLE_MD_IDLE && crosses)) begin
            if (hnest_q == HMAX || (|lock_hit) || crosses) begin
              ab_go = 1'b1;
              ab_st[tle_pkg::TLE_AB_OVERFLOW] = (hnest_q == HMAX);
            end else begin
              hnest_d = hnest_q + 1'b1;
              if (mode_q == tle_pkg::TLE_MD_IDLE) begin
                mode_d = tle_pkg::TLE_MD_ELIDE;
                rpc_d = op_pc;
              end
              rs_ins = 1'b1;
              if (free_slot[SW]) begin
                slot_take = 1'b1;
                slot_v_d[free_slot[SW-1:0]] = 1'b1;
              end else begin
                wr_go = 1'b1;
                wr_spec = 1'b1;
                ws_ins = 1'b1;
              end
            end
          end else begin
            wr_go = 1'b1;
            wr_spec = in_tx;
            ws_ins = in_tx;
            if (op_hint && no_elide_q) pnest_d = pnest_q + 1'b1;
          end
        end
        tle_pkg::TLE_OP_REL: begin
          if (op_hint && mode_q == tle_pkg::TLE_MD_ELIDE) begin
            if ((|lock_hit) && (slot_sz_q[hit_idx] != op_size
                || slot_old_q[hit_idx] != op_wdata)) begin
              ab_go = 1'b1;
            end else begin
              if (|lock_hit) begin
                slot_free = 1'b1;
                slot_v_d[hit_idx] = 1'b0;
              end else begin
                wr_go = 1'b1;
                wr_spec = 1'b1;
                ws_ins = 1'b1;
              end
              hnest_d = hnest_q - 1'b1;
              if (hnest_q == NW'(1)) begin
                if (slot_v_d != '0) ab_go = 1'b1;
                else cm_go = 1'b1;
              end
            end
          end else begin
            wr_go = 1'b1;
            wr_spec = in_tx;
            ws_ins = in_tx;
            if (op_hint && no_elide_q) begin
              pnest_d = pnest_q - 1'b1;
              if (pnest_q <= NW'(1)) begin
                pnest_d = '0;
                no_elide_d = 1'b0;
              end
            end
          end
        end
        tle_pkg::TLE_OP_BEGIN: begin
          if (!region_on) begin
            flt = 1'b1;
          end else if (mode_q == tle_pkg::TLE_MD_ELIDE) begin
            ab_go = 1'b1;
          end else if (rnest_q == RMAX) begin
            ab_go = 1'b1;
            ab_st[tle_pkg::TLE_AB_OVERFLOW] = 1'b1;
          end else begin
            rnest_d = rnest_q + 1'b1;
            if (mode_q == tle_pkg::TLE_MD_IDLE) begin
              mode_d = tle_pkg::TLE_MD_REGION;
              fb_d = op_next_pc + op_offset[ADDR_W-1:0];
            end
          end
        end
        tle_pkg::TLE_OP_END: begin
          if (!region_on || mode_q != tle_pkg::TLE_MD_REGION) begin
            flt = 1'b1;
          end else begin
            rnest_d = rnest_q - 1'b1;
            cm_go = (rnest_q == NW'(1));
          end
        end
        tle_pkg::TLE_OP_ABORT: begin
          if (!region_on) begin
            flt = 1'b1;
          end else if (in_tx) begin
            ab_go = 1'b1;
            ab_st[tle_pkg::TLE_AB_EXPLICIT] = 1'b1;
            ab_st[31:tle_pkg::TLE_AB_IMM_LSB] = op_imm;
          end
        end
        tle_pkg::TLE_OP_TEST: begin
          if (!elide_on && !region_on) begin
            flt = 1'b1;
          end else begin
            res_v = 1'b1;
            res_d = {31'h0, in_tx};
          end
        end
        tle_pkg::TLE_OP_QUERY: begin
          if (in_tx) begin
            ab_go = 1'b1;
          end else begin
            res_v = 1'b1;
            if (op_wdata == tle_pkg::TLE_LEAF_EXT) begin
              res_d[tle_pkg::TLE_FEAT_ELIDE] = elide_on;
              res_d[tle_pkg::TLE_FEAT_REGION] = region_on;
            end
          end
        end
        tle_pkg::TLE_OP_DEBUG: begin
          if (in_tx) begin
            ab_go = 1'b1;
            ab_st[tle_pkg::TLE_AB_DEBUG] = 1'b1;
          end
        end
        default: begin
          flt = 1'b1;
        end
      endcase
    end
    // conflicts from other processors and capacity overflow
    if (in_tx && snoop_valid && ((snoop_write && (rs_hit || ws_hit)) || ws_hit)) begin
      ab_go = 1'b1;
      ab_st[tle_pkg::TLE_AB_CONFLICT] = 1'b1;
      ab_st[tle_pkg::TLE_AB_RETRY] = !ab_st[tle_pkg::TLE_AB_EXPLICIT];
    end
    if (in_tx && ((rs_ovf && rs_ins) || (ws_ovf && ws_ins))) begin
      ab_go = 1'b1;
      ab_st[tle_pkg::TLE_AB_OVERFLOW] = 1'b1;
    end
    ab_st[tle_pkg::TLE_AB_NESTED] = (rnest_q > NW'(1));
    if (ab_go) cm_go = 1'b0;
    if (ab_go || cm_go) begin
      mode_d = tle_pkg::TLE_MD_IDLE;
      hnest_d = '0;
      rnest_d = '0;
      slot_v_d = '0;
      if (ab_go && mode_q == tle_pkg::TLE_MD_ELIDE) begin
        no_elide_d = 1'b1;
        pnest_d = '0;
      end
    end
  end

  assign set_clr = ab_go || cm_go;

  // transactional mode, counters and return points
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= tle_pkg::TLE_MD_IDLE;
      hnest_q <= '0;
      rnest_q <= '0;
      pnest_q <= '0;
      no_elide_q <= 1'b0;
      rpc_q <= '0;
      fb_q <= '0;
    end else begin
      mode_q <= mode_d;
      hnest_q <= hnest_d;
      rnest_q <= rnest_d;
      pnest_q <= pnest_d;
      no_elide_q <= no_elide_d;
      rpc_q <= rpc_d;
      fb_q <= fb_d;
    end
  end

  // elided-lock slots: address, size, prior value and acquire value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_v_q <= '0;
      for (int i = 0; i < SLOTS; i++) begin
        slot_a_q[i] <= '0;
        slot_sz_q[i] <= '0;
        slot_old_q[i] <= '0;
        slot_new_q[i] <= '0;
      end
    end else begin
      slot_v_q <= slot_v_d;
      if (slot_take && !ab_go) begin
        slot_a_q[free_slot[SW-1:0]] <= op_addr;
        slot_sz_q[free_slot[SW-1:0]] <= op_size;
        slot_old_q[free_slot[SW-1:0]] <= op_mem_rdata;
        slot_new_q[free_slot[SW-1:0]] <= op_wdata;
      end
    end
  end

  // core-facing results, redirects and memory write requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid <= 1'b0;
      res_data <= '0;
      fault_invalid_op <= 1'b0;
      redirect_valid <= 1'b0;
      redirect_pc <= '0;
      status_valid <= 1'b0;
      status_result_reg <= '0;
      commit_pulse <= 1'b0;
      abort_pulse <= 1'b0;
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= '0;
      mem_wr_size <= '0;
      mem_wr_spec <= 1'b0;
    end else begin
      res_valid <= res_v && !ab_go;
      res_data <= res_d;
      fault_invalid_op <= flt;
      redirect_valid <= ab_go;
      redirect_pc <= (mode_q == tle_pkg::TLE_MD_REGION) ? fb_q : rpc_q;
      status_valid <= ab_go && mode_q == tle_pkg::TLE_MD_REGION;
      if (ab_go && mode_q == tle_pkg::TLE_MD_REGION) status_result_reg <= ab_st;
      commit_pulse <= cm_go;
      abort_pulse <= ab_go;
      mem_wr_valid <= wr_go && !ab_go;
      mem_wr_addr <= op_addr;
      mem_wr_data <= op_wdata;
      mem_wr_size <= op_size;
      mem_wr_spec <= wr_spec;
    end
  end

  // apb: control writes at the access edge, read data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= tle_pkg::TLE_CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == tle_pkg::TLE_OFF_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // event statistics and last abort status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_st_q <= '0;
      nabort_q <= '0;
      ncommit_q <= '0;
    end else begin
      if (ab_go) ab_st_q <= ab_st;
      if (ab_go) nabort_q <= nabort_q + 32'h0000_0001;
      if (cm_go) ncommit_q <= ncommit_q + 32'h0000_0001;
    end
  end

  // read mux and unmapped-address error, latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= '0;
      case (paddr)
        tle_pkg::TLE_OFF_CTRL: prdata <= {30'h0, ctrl_q};
        tle_pkg::TLE_OFF_STATE: begin
          prdata[tle_pkg::TLE_ST_INTX_BIT] <= in_tx;
          prdata[tle_pkg::TLE_ST_MODE_LSB +: 2] <= mode_q;
          prdata[tle_pkg::TLE_ST_NOELIDE_BIT] <= no_elide_q;
          prdata[tle_pkg::TLE_ST_HNEST_LSB +: NW] <= hnest_q;
          prdata[tle_pkg::TLE_ST_RNEST_LSB +: NW] <= rnest_q;
          prdata[tle_pkg::TLE_ST_SLOTS_LSB +: 8] <= 8'(SLOTS);
        end
        tle_pkg::TLE_OFF_ABORT: prdata <= ab_st_q;
        tle_pkg::TLE_OFF_NABORT: prdata <= nabort_q;
        tle_pkg::TLE_OFF_NCOMMIT: prdata <= ncommit_q;
        default: pslverr <= 1'b1;
      endcase
    end
  end

  assign pready = 1'b1;

endmodule
`default_nettype wire

// ### hdl/tle_line_set.sv
// cache-line address set used for read-set and write-set tracking
`timescale 1ns/1ns
`default_nettype none
module tle_line_set #(
  parameter int LINE_W = 26,
  parameter int DEPTH  = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clr,
  input  wire logic              ins_valid,
  input  wire logic [LINE_W-1:0] ins_line,
  input  wire logic [LINE_W-1:0] chk_line,
  output logic                   chk_hit,
  output logic                   ins_ovf
);

  initial begin
    if (DEPTH < 1 || LINE_W < 1) $error("tle_line_set: bad parameters");
  end

  logic [LINE_W-1:0] line_q [DEPTH];
  logic [DEPTH-1:0]  vld_q;
  logic [DEPTH-1:0]  chk_v;
  logic [DEPTH-1:0]  ins_v;
  logic [DEPTH-1:0]  free_oh;

  // per-entry compares for snoop lookup and duplicate insert
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cmp
      assign chk_v[g] = vld_q[g] && (line_q[g] == chk_line);
      assign ins_v[g] = vld_q[g] && (line_q[g] == ins_line);
    end
  endgenerate

  // lowest free entry, one-hot
  assign free_oh = ~vld_q & (vld_q + 1'b1);
  assign chk_hit = |chk_v;
  assign ins_ovf = ins_valid && !(|ins_v) && (&vld_q); // capacity exceeded

  // valid bits, cleared at reset, commit and abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld_q <= '0;
    end else if (clr) begin
      vld_q <= '0;
    end else if (ins_valid && !(|ins_v)) begin
      vld_q <= vld_q | free_oh;
    end
  end

  // line tags of the set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) line_q[i] <= '0;
    end else if (!clr && ins_valid && !(|ins_v)) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (free_oh[i]) line_q[i] <= ins_line;
      end
    end
  end

endmodule
`default_nettype wire

// ### hdl/tle_pkg.sv
// package: constants, register map and encodings of the transactional control block
package tle_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] TLE_OFF_CTRL   = 12'h000;
  localparam logic [11:0] TLE_OFF_STATE  = 12'h004;
  localparam logic [11:0] TLE_OFF_ABORT  = 12'h008;
  localparam logic [11:0] TLE_OFF_NABORT = 12'h00C;
  localparam logic [11:0] TLE_OFF_NCOMMIT = 12'h010;

  // control register fields and reset value
  localparam int          TLE_CTRL_ELIDE_BIT  = 0;
  localparam int          TLE_CTRL_REGION_BIT = 1;
  localparam logic [1:0]  TLE_CTRL_RESET      = 2'h3;

  // state register fields
  localparam int TLE_ST_INTX_BIT   = 0;
  localparam int TLE_ST_MODE_LSB   = 1;
  localparam int TLE_ST_NOELIDE_BIT = 3;
  localparam int TLE_ST_HNEST_LSB  = 8;
  localparam int TLE_ST_RNEST_LSB  = 16;
  localparam int TLE_ST_SLOTS_LSB  = 24;

  // abort status word layout
  localparam int TLE_AB_EXPLICIT = 0;
  localparam int TLE_AB_RETRY    = 1;
  localparam int TLE_AB_CONFLICT = 2;
  localparam int TLE_AB_OVERFLOW = 3;
  localparam int TLE_AB_DEBUG    = 4;
  localparam int TLE_AB_NESTED   = 5;
  localparam int TLE_AB_IMM_LSB  = 24;

  // feature query leaf and its reported bits
  localparam logic [31:0] TLE_LEAF_EXT     = 32'h0000_0007;
  localparam int          TLE_FEAT_ELIDE   = 4;
  localparam int          TLE_FEAT_REGION  = 11;

  // instruction kinds presented by the core
  typedef enum logic [3:0] {
    TLE_OP_LOAD   = 4'h0,
    TLE_OP_STORE  = 4'h1,
    TLE_OP_ACQ    = 4'h2,
    TLE_OP_REL    = 4'h3,
    TLE_OP_BEGIN  = 4'h4,
    TLE_OP_END    = 4'h5,
    TLE_OP_ABORT  = 4'h6,
    TLE_OP_TEST   = 4'h7,
    TLE_OP_QUERY  = 4'h8,
    TLE_OP_DEBUG  = 4'h9
  } tle_op_e;

  // transactional mode, gray along idle -> elide -> region
  typedef enum logic [1:0] {
    TLE_MD_IDLE   = 2'h0,
    TLE_MD_ELIDE  = 2'h1,
    TLE_MD_REGION = 2'h3
  } tle_mode_e;

endpackage

// ### sim/tb_transactional_lock_elision.sv
// self-checking bench for the transactional control block
`timescale 1ns/1ns
`default_nettype none
module tb_transactional_lock_elision;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic op_valid = 0, op_ready, op_hint = 0, res_valid, fault_invalid_op, in_tx;
  logic redirect_valid, status_valid, commit_pulse, abort_pulse, mem_wr_valid, mem_wr_spec;
  logic snoop_valid = 0, snoop_write = 0;
  logic [1:0] op_size = 2'h2, mem_wr_size;
  logic [3:0] op_kind = 0;
  logic [7:0] op_imm = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, op_addr = 0, op_wdata = 0, op_mem_rdata, op_offset = 0;
  logic [31:0] op_pc = 32'hFC, op_next_pc = 32'h100, res_data, redirect_pc, status_result_reg;
  logic [31:0] mem_wr_addr, mem_wr_data, snoop_addr = 0;
  int n_fail = 0, checks_done = 0, i;
  tle_core dut (.*);
  tle_mem_model u_mem (.*);
  always #10 pclk = ~pclk;
  // compare and report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // bounded wait for a ready at an edge
  task automatic wt(input bit a);
    for (int k = 0; k < 8; k++) begin
      @(posedge pclk);
      if ((a ? pready : op_ready) === 1'b1) return;
    end
    n_fail++;
    end_of_test();
  endtask
  // one apb transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e, input logic ee);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    wt(1);
    chk(32'(pslverr), 32'(ee));
    if (!w) chk(prdata, e);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // one instruction, answer read at the next edge
  task automatic op(input logic [3:0] k, input logic h, input logic [31:0] a, w, x);
    op_kind <= k;
    op_hint <= h;
    op_addr <= a;
    op_wdata <= w;
    op_imm <= x[7:0];
    op_offset <= x;
    op_valid <= 1;
    wt(0);
    op_valid <= 0;
    @(posedge pclk);
  endtask
  task automatic snoop(input logic w, input logic [31:0] a);
    snoop_valid <= 1;
    snoop_write <= w;
    snoop_addr <= a;
    @(posedge pclk);
    snoop_valid <= 0;
    @(posedge pclk);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, tle_pkg::TLE_OFF_CTRL, 0, 32'h3, 0);
    apb(0, 12'h014, 0, 0, 1);
    op(tle_pkg::TLE_OP_QUERY, 0, 0, 32'h7, 0);
    chk(32'({res_data[11], res_data[4]}), 32'h3);
    // single elided lock
    op(tle_pkg::TLE_OP_ACQ, 1, 32'h40, 1, 0);
    chk({in_tx, res_valid, mem_wr_valid, res_data[0]}, 32'hC);
    op(tle_pkg::TLE_OP_LOAD, 0, 32'h40, 0, 0);
    chk(res_data, 32'h1);
    snoop(0, 32'h40);
    chk({in_tx, abort_pulse}, 32'h2);
    op(tle_pkg::TLE_OP_REL, 1, 32'h40, 0, 0);
    chk({commit_pulse, mem_wr_valid, in_tx}, 32'h4);
    // three locks, two slots
    for (i = 0; i < 3; i++) op(tle_pkg::TLE_OP_ACQ, 1, 32'h80 + 64 * i, 1, 0);
    chk({in_tx, mem_wr_valid, mem_wr_spec}, 32'h7);
    for (i = 2; i >= 0; i--) begin
      op(tle_pkg::TLE_OP_REL, 1, 32'h80 + 64 * i, 0, 0);
      chk(32'(commit_pulse), 32'(i == 0));
    end
    // nested regions, explicit abort
    op(tle_pkg::TLE_OP_BEGIN, 0, 0, 0, 32'h20);
    op(tle_pkg::TLE_OP_BEGIN, 0, 0, 0, 32'h40);
    op(tle_pkg::TLE_OP_TEST, 0, 0, 0, 0);
    chk(32'(res_data[0]), 32'h1);
    op(tle_pkg::TLE_OP_ABORT, 0, 0, 0, 32'h5A);
    chk(redirect_pc, 32'h120);
    chk(status_result_reg, 32'h5A00_0021);
    // write to a line in the read-set
    op(tle_pkg::TLE_OP_BEGIN, 0, 0, 0, 32'h20);
    op(tle_pkg::TLE_OP_LOAD, 0, 32'h200, 0, 0);
    snoop(1, 32'h23C);
    chk({redirect_valid, status_result_reg[5:0]}, 32'h46);
    // both modes off
    apb(1, tle_pkg::TLE_OFF_CTRL, 0, 0, 0);
    op(tle_pkg::TLE_OP_QUERY, 0, 0, 32'h7, 0);
    chk(32'({res_data[11], res_data[4]}), 32'h0);
    op(tle_pkg::TLE_OP_BEGIN, 0, 0, 0, 32'h20);
    chk(32'(fault_invalid_op), 32'h1);
    op(tle_pkg::TLE_OP_TEST, 0, 0, 0, 0);
    chk(32'(fault_invalid_op), 32'h1);
    op(tle_pkg::TLE_OP_ACQ, 1, 32'h40, 1, 0);
    chk({in_tx, mem_wr_valid, mem_wr_spec}, 32'h2);
    end_of_test();
  end
endmodule
`default_nettype wire

// ### sim/tle_core_asserts.sv
// assertions on the control block ports
`timescale 1ns/1ns
`default_nettype none
module tle_core_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic [3:0]  op_kind,
  input wire logic        op_hint,
  input wire logic [7:0]  op_imm,
  input wire logic        in_tx,
  input wire logic        mem_wr_valid,
  input wire logic        commit_pulse,
  input wire logic        abort_pulse,
  input wire logic        redirect_valid,
  input wire logic        status_valid,
  input wire logic [31:0] status_result_reg
);
  // an instruction is taken at this edge
  wire logic tk = op_valid && op_ready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // hinted lock writes stay hidden
  property p_acq_quiet;
    tk && op_kind == tle_pkg::TLE_OP_ACQ && op_hint && !in_tx ##1 in_tx |-> !mem_wr_valid;
  endproperty
  a_acq_quiet: assert property (p_acq_quiet) else $error("elided acquire wrote");
  property p_rel_quiet;
    tk && op_kind == tle_pkg::TLE_OP_REL && op_hint ##1 commit_pulse |-> !mem_wr_valid && !in_tx;
  endproperty
  a_rel_quiet: assert property (p_rel_quiet) else $error("elided release wrote");
  // explicit abort, abort status, rollback and commit
  property p_explicit_abort_op; tk && op_kind == tle_pkg::TLE_OP_ABORT && in_tx |=> abort_pulse; endproperty
  a_explicit_abort_op: assert property (p_explicit_abort_op) else $error("explicit abort ignored");
  property p_imm;
    tk && op_kind == tle_pkg::TLE_OP_ABORT ##1 status_valid
      |-> status_result_reg[31:24] == $past(op_imm) && status_result_reg[0];
  endproperty
  a_imm: assert property (p_imm) else $error("abort immediate lost");
  property p_retry; status_valid && status_result_reg[0] |-> !status_result_reg[1]; endproperty
  a_retry: assert property (p_retry) else $error("retry set on explicit abort");
  property p_status; status_valid |-> redirect_valid && abort_pulse; endproperty
  a_status: assert property (p_status) else $error("status without redirect");
  property p_rollback; abort_pulse |-> !in_tx && !commit_pulse; endproperty
  a_rollback: assert property (p_rollback) else $error("abort left transaction open");
  property p_commit; commit_pulse |-> $past(in_tx) && !in_tx; endproperty
  a_commit: assert property (p_commit) else $error("commit outside transaction");
endmodule
bind tle_core tle_core_asserts u_chk (.*);
`default_nettype wire

// ### sim/tle_mem_model.sv
// shared memory model seen by the core
`timescale 1ns/1ns
`default_nettype none
module tle_mem_model (
  input  wire logic        pclk,
  input  wire logic [31:0] op_addr,
  output logic [31:0]      op_mem_rdata,
  input  wire logic        mem_wr_valid,
  input  wire logic        mem_wr_spec,
  input  wire logic [31:0] mem_wr_addr,
  input  wire logic [31:0] mem_wr_data
);
  logic [31:0] mem [16];
  initial foreach (mem[i]) mem[i] = '0;
  // reads see non-speculative writes only
  assign op_mem_rdata = mem[op_addr[5:2]];
  // speculative writes never land
  always @(posedge pclk) begin
    if (mem_wr_valid && !mem_wr_spec) mem[mem_wr_addr[5:2]] <= mem_wr_data;
  end
endmodule
`default_nettype wire
